// file: uart_serial_port_consts.vh
// Constants of the serial port: register offsets, field positions, reset values and timing counts.
// Assumes an APB slave with byte addresses in the low eight address bits.
`ifndef UART_SERIAL_PORT_CONSTS_VH
`define UART_SERIAL_PORT_CONSTS_VH

// Register byte offsets
`define OFS_SERIAL_BUFFER   8'h00
`define OFS_SERIAL_CONTROL  8'h04
`define OFS_CONFIG          8'h08
`define OFS_IRQ_STATUS      8'h0C
`define OFS_IRQ_MASK        8'h10

// Control register fields
`define CTL_MODE_HI         7
`define CTL_MODE_LO         6
`define CTL_SPEED           5
`define CTL_REN             4
`define CTL_TX_NINTH        3
`define CTL_RX_NINTH        2
`define CTL_TX_DONE         1
`define CTL_RX_DONE         0

// Configuration and interrupt fields
`define CFG_DOUBLER         0
`define ST_RX_DONE          0
`define ST_TX_DONE          1
`define ST_RX_ABORT         2

// Reset values
`define CTL_RESET           5'h00
`define CFG_RESET           1'h0
`define STATUS_RESET        3'h0
`define MASK_RESET          3'h0
`define BUF_RESET           8'h00

// Mode 0 bit timing in clock periods: period, falling point, rising point
`define M0_FAST_PERIOD      4'h4
`define M0_FAST_FALL        4'h1
`define M0_FAST_RISE        4'h3
`define M0_SLOW_PERIOD      4'hC
`define M0_SLOW_FALL        4'h3
`define M0_SLOW_RISE        4'h9
`define M0_LAST_BIT         4'h7

// Asynchronous timing: clocks per slice, slices per bit, sample slices, frame length
`define SLICE_DIV_DOUBLE    3'h2
`define SLICE_DIV_SINGLE    3'h4
`define SLICE_LAST          4'hF
`define SAMPLE_FIRST        4'h7
`define SAMPLE_SECOND       4'h8
`define SAMPLE_THIRD        4'h9
`define RX_NINTH_INDEX      4'h9
`define RX_STOP_INDEX       4'hA
`define TX_LAST_INDEX       4'hA

`endif

// file: uart_serial_port.v
// Serial port with synchronous shift mode 0 and the asynchronous 11-bit mode, behind an APB slave.
// Assumes rxd_in and any other pin input are asynchronous to pclk; the bus master follows APB.
`timescale 1ns/1ns
`include "uart_serial_port_consts.vh"

// What this block does
// [R1] Buffer write loads transmit, read returns receive
// [R2] Mode 0: data pin both ways, clock always driven
// [R3] Mode 0 frame: eight bits, LSB first
// [R4] Mode 0 rate: clock/12, or clock/4 when set
// [R5] Mode 0 buffer write starts an eight-bit send
// [R6] Fast: data one period before fall, low two
// [R7] Slow: data three periods before fall, low six
// [R8] Sixteen slices, samples 7-9, majority vote
// [R9] Start bit not zero aborts, hunt again
// [R10] Load after ninth bit if flag clear, condition
// [R11] Ninth bit to flag, data to buffer
// [R12] After stop middle, watch for next falling edge
// [R13] Asynchronous transmit and receive run independently
// [R14] Mode 2 frame: start, eight data, ninth, stop
// [R15] Mode 2 ninth received bit stored in flag
// [R16] Mode 2 rate: clock/32 or clock/64 by doubler
// [R17] Mode 0 receive needs enable and clear flag
// [R18] Falling edge in idle restarts slice counter
module uart_serial_port (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        rxd_in,
	output reg         rxd_out,
	output reg         rxd_oe,
	output reg         txd_out,
	output reg         irq
);

	// Two-of-three majority
	function maj3;
		input a;
		input b;
		input c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction

	// Software-visible state
	reg [4:0]  ctl;           // Mode[1:0], speed, receive enable, transmit ninth bit
	reg        baud_doubler_select;
	reg [2:0]  status;
	reg [2:0]  mask;
	reg [7:0]  rx_buf;
	reg        received_ninth_bit;
	reg [7:0]  tx_data;
	reg        tx_req;

	// Pin synchroniser and edge history
	reg [1:0]  rxd_sync;
	reg        rxd_prev;

	// Slice prescaler shared by both asynchronous engines
	reg [2:0]  pre;

	// Asynchronous receiver
	reg        rx_busy;
	reg [3:0]  rx_slice;
	reg [3:0]  rx_bit;
	reg [1:0]  votes;
	reg [7:0]  rx_shift;

	// Asynchronous transmitter
	reg        tx_busy;
	reg [3:0]  tx_slice;
	reg [3:0]  tx_bit;
	reg [10:0] tx_frame;

	// Mode 0 shift engine
	reg        m0_busy;
	reg        m0_is_tx;
	reg [3:0]  m0_phase;
	reg [3:0]  m0_bit;
	reg [7:0]  m0_shift;

	wire       rxd_s = rxd_sync[1];
	wire [1:0] mode = ctl[4:3];
	wire       mode0 = (mode == 2'b00);
	wire       speed = ctl[2];
	wire       ren = ctl[1];
	wire       transmit_ninth_bit = ctl[0];
	wire       receive_done_flag = status[`ST_RX_DONE];
	wire [3:0] m0_period = speed ? `M0_FAST_PERIOD : `M0_SLOW_PERIOD; // [R4]
	wire [3:0] m0_fall = speed ? `M0_FAST_FALL : `M0_SLOW_FALL;       // [R6] [R7]
	wire [3:0] m0_rise = speed ? `M0_FAST_RISE : `M0_SLOW_RISE;       // [R6] [R7]
	wire [2:0] pre_div = baud_doubler_select ? `SLICE_DIV_DOUBLE : `SLICE_DIV_SINGLE; // [R16]

	// Bus decode
	wire       acc = psel & penable & pready;
	wire       wr = acc & pwrite;
	wire       hit_buf = (paddr == `OFS_SERIAL_BUFFER);
	wire       hit_ctl = (paddr == `OFS_SERIAL_CONTROL);
	wire       hit_cfg = (paddr == `OFS_CONFIG);
	wire       hit_st = (paddr == `OFS_IRQ_STATUS);
	wire       hit_mask = (paddr == `OFS_IRQ_MASK);
	wire       mapped = hit_buf | hit_ctl | hit_cfg | hit_st | hit_mask;

	// Engine events
	wire       slice_tick = (pre == pre_div - 3'h1);
	wire       rx_fall = rxd_prev & ~rxd_s;
	wire       rx_vote_now = rx_busy & slice_tick & (rx_slice == `SAMPLE_THIRD);
	wire       rx_vote = maj3(votes[0], votes[1], rxd_s);                              // [R8]
	wire       rx_abort_ev = rx_vote_now & (rx_bit == 4'h0) & rx_vote;                 // [R9]
	wire       rx_ninth_ev = rx_vote_now & (rx_bit == `RX_NINTH_INDEX);
	wire       rx_load_ev = rx_ninth_ev & ~receive_done_flag & (~speed | rx_vote);    // [R10]
	wire       tx_end_ev = tx_busy & slice_tick & (tx_slice == `SLICE_LAST) & (tx_bit == `TX_LAST_INDEX);
	wire       m0_bit_end = m0_busy & (m0_phase == m0_period - 4'h1);
	wire       m0_end = m0_bit_end & (m0_bit == `M0_LAST_BIT);                         // [R3]
	wire       m0_rx_start = mode0 & ~m0_busy & ~tx_req & ren & ~receive_done_flag;    // [R17]
	wire       m0_rx_load = m0_end & ~m0_is_tx;

	// Interrupt status set and clear vectors
	wire [2:0] st_set = {rx_abort_ev, tx_end_ev | (m0_end & m0_is_tx), rx_load_ev | m0_rx_load};
	wire [2:0] st_clr = (wr & hit_st) ? pwdata[2:0] : 3'h0;

	// APB slave: one wait state, registered read data and error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= 32'h0000_0000;
			if (psel & penable & ~pready & ~pwrite) begin
				if (hit_buf)
					prdata <= {24'h00_0000, rx_buf};                 // [R1]
				else if (hit_ctl)
					prdata <= {24'h00_0000, ctl, received_ninth_bit,
						status[`ST_TX_DONE], status[`ST_RX_DONE]};
				else if (hit_cfg)
					prdata <= {31'h0000_0000, baud_doubler_select};
				else if (hit_st)
					prdata <= {29'h0000_0000, status};
				else if (hit_mask)
					prdata <= {29'h0000_0000, mask};
			end
		end
	end

	// Software registers and sticky status; a hardware set wins over a clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= `CTL_RESET;
			baud_doubler_select <= `CFG_RESET;
			status <= `STATUS_RESET;
			mask <= `MASK_RESET;
			irq <= 1'b0;
		end else begin
			if (wr & hit_ctl)
				ctl <= pwdata[`CTL_MODE_HI:`CTL_TX_NINTH];
			if (wr & hit_cfg)
				baud_doubler_select <= pwdata[`CFG_DOUBLER];
			if (wr & hit_mask)
				mask <= pwdata[2:0];
			status <= (status & ~st_clr) | st_set;
			irq <= |(((status & ~st_clr) | st_set) & mask);
		end
	end

	// Transmit holding register: a buffer write requests a frame
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data <= `BUF_RESET;
			tx_req <= 1'b0;
		end else if (wr & hit_buf) begin
			tx_data <= pwdata[7:0];                                      // [R1]
			tx_req <= 1'b1;                                              // [R5]
		end else if (tx_req & (mode0 ? ~m0_busy : ~tx_busy)) begin
			tx_req <= 1'b0;
		end
	end

	// Receive pin synchroniser and previous level
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_sync <= 2'b11;
			rxd_prev <= 1'b1;
		end else begin
			rxd_sync <= {rxd_sync[0], rxd_in};
			rxd_prev <= rxd_sync[1];
		end
	end

	// Slice prescaler, two or four clocks per slice
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pre <= 3'h0;
		else if (slice_tick)
			pre <= 3'h0;
		else
			pre <= pre + 3'h1;
	end

	// Asynchronous receiver: start, eight data, ninth bit, stop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_busy <= 1'b0;
			rx_slice <= 4'h0;
			rx_bit <= 4'h0;
			votes <= 2'b00;
			rx_shift <= 8'h00;
		end else if (!rx_busy) begin
			if (!mode0 & ren & rx_fall) begin
				rx_busy <= 1'b1;
				rx_slice <= 4'h0;                                        // [R18]
				rx_bit <= 4'h0;
			end
		end else if (slice_tick) begin
			rx_slice <= rx_slice + 4'h1;                                 // [R8]
			if (rx_slice == `SAMPLE_FIRST)
				votes[0] <= rxd_s;                                       // [R8]
			if (rx_slice == `SAMPLE_SECOND)
				votes[1] <= rxd_s;                                       // [R8]
			if (rx_slice == `SLICE_LAST)
				rx_bit <= rx_bit + 4'h1;
			if (rx_vote_now) begin
				if (rx_bit == 4'h0) begin
					if (rx_vote)
						rx_busy <= 1'b0;                                 // [R9]
				end else if (rx_bit < `RX_NINTH_INDEX) begin
					rx_shift <= {rx_vote, rx_shift[7:1]};                // [R14]
				end else if (rx_bit == `RX_STOP_INDEX) begin
					rx_busy <= 1'b0;                                     // [R12]
				end
			end
		end
	end

	// Asynchronous transmitter, independent of the receiver
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy <= 1'b0;
			tx_slice <= 4'h0;
			tx_bit <= 4'h0;
			tx_frame <= 11'h7FF;
		end else if (!tx_busy) begin
			if (!mode0 & tx_req) begin
				tx_busy <= 1'b1;                                         // [R13]
				tx_slice <= 4'h0;
				tx_bit <= 4'h0;
				tx_frame <= {1'b1, transmit_ninth_bit, tx_data, 1'b0};   // [R14]
			end
		end else if (slice_tick) begin
			tx_slice <= tx_slice + 4'h1;
			if (tx_slice == `SLICE_LAST) begin
				tx_frame <= {1'b1, tx_frame[10:1]};
				tx_bit <= tx_bit + 4'h1;
				if (tx_bit == `TX_LAST_INDEX)
					tx_busy <= 1'b0;
			end
		end
	end

	// Mode 0 shift engine, transmit has priority over receive
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m0_busy <= 1'b0;
			m0_is_tx <= 1'b0;
			m0_phase <= 4'h0;
			m0_bit <= 4'h0;
			m0_shift <= 8'h00;
		end else if (!m0_busy) begin
			m0_phase <= 4'h0;
			m0_bit <= 4'h0;
			if (mode0 & tx_req) begin
				m0_busy <= 1'b1;                                         // [R5]
				m0_is_tx <= 1'b1;
				m0_shift <= tx_data;
			end else if (m0_rx_start) begin
				m0_busy <= 1'b1;                                         // [R17]
				m0_is_tx <= 1'b0;
			end
		end else begin
			m0_phase <= m0_phase + 4'h1;
			if (!m0_is_tx & (m0_phase == m0_rise))
				m0_shift <= {rxd_s, m0_shift[7:1]};                      // [R3]
			if (m0_bit_end) begin
				m0_phase <= 4'h0;
				m0_bit <= m0_bit + 4'h1;
				if (m0_is_tx)
					m0_shift <= {1'b0, m0_shift[7:1]};                   // [R3]
				if (m0_end)
					m0_busy <= 1'b0;
			end
		end
	end

	// Receive buffer and ninth-bit flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf <= `BUF_RESET;
			received_ninth_bit <= 1'b0;
		end else if (rx_load_ev) begin
			rx_buf <= rx_shift;                                          // [R11]
			received_ninth_bit <= rx_vote;                               // [R11] [R15]
		end else if (m0_rx_load) begin
			rx_buf <= m0_shift;                                          // [R11]
		end
	end

	// Pins: mode 0 drives the shift clock on txd and data on rxd
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_out <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
		end else if (mode0) begin
			txd_out <= ~(m0_busy & (m0_phase >= m0_fall) & (m0_phase < m0_rise)); // [R2] [R6] [R7]
			rxd_out <= m0_busy & m0_is_tx ? m0_shift[0] : 1'b1;          // [R2]
			rxd_oe <= m0_busy & m0_is_tx;                                // [R2]
		end else begin
			txd_out <= tx_busy ? tx_frame[0] : 1'b1;                     // [R14]
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
		end
	end

endmodule

// file: uart_serial_port_asserts.sv
// Checker: bus answer timing and mode 0 pin timing of the serial port.
// Assumes it is bound to uart_serial_port and sees only its ports.
`timescale 1ns/1ns
module uart_serial_port_asserts (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        rxd_out,
	input wire        rxd_oe,
	input wire        txd_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answer
	a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready late or early");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("pslverr without pready or with data");
	a_rdata_idle: assert property (!pready || pwrite |-> prdata == 32'h0000_0000)
		else $error("prdata not zero outside a read answer");
	// Mode 0 pins
	a_oe_idle: assert property (!rxd_oe |-> rxd_out)
		else $error("data pin output not high while released");
	a_low_run: assert property (rxd_oe && $fell(txd_out) |->
		(!txd_out [*2] ##1 txd_out) or (!txd_out [*6] ##1 txd_out))
		else $error("shift clock low run wrong");
	a_data_stable: assert property (rxd_oe && !txd_out |-> $stable(rxd_out))
		else $error("data moved while shift clock low");
	a_clock_starts: assert property ($rose(rxd_oe) |-> ##[1:12] !txd_out)
		else $error("shift clock did not start");
endmodule

// file: uart_far_end.sv
// Far-end model: shift register for mode 0, serial transceiver for the asynchronous mode.
// Assumes the bench routes line to the data pin input whenever the block releases it.
`timescale 1ns/1ns
module uart_far_end (
	input  wire       pclk,
	input  wire       txd_out,
	input  wire       rxd_out,
	input  wire       rxd_oe,
	output reg        line,
	output reg        got,
	output reg  [9:0] got_val,
	output reg  [3:0] last_low
);
	reg        async;
	reg  [7:0] m0_tx;
	reg  [7:0] sh;
	reg  [3:0] low_n;
	reg        txd_q;
	reg [10:0] fr;
	int        bit_clks;
	int        n;
	int        i;
	initial begin
		line = 1'b1;
		got = 1'b0;
		async = 1'b0;
		n = 0;
		i = 0;
		bit_clks = 32;
	end
	// Mode 0: take data at each clock fall, present the next bit after each rise
	always @(posedge pclk) begin
		txd_q <= txd_out;
		low_n <= txd_out ? 4'h0 : low_n + 4'h1;
		if (!async)
			got <= 1'b0;
		if (txd_out && !txd_q)
			last_low <= low_n;
		if (!async && txd_q && !txd_out && rxd_oe) begin
			sh = {rxd_out, sh[7:1]};
			n = n + 1;
			if (n == 8) begin
				got <= 1'b1;
				got_val <= {2'b10, sh};
				n = 0;
			end
		end
		if (!async && !rxd_oe && txd_out && !txd_q) begin
			i = i + 1;
			line <= m0_tx[i % 8];
		end
	end
	// Asynchronous receiver: centre samples of each bit of the block's frame
	always begin
		@(posedge pclk);
		if (async && txd_q && !txd_out) begin
			repeat (bit_clks / 2) @(posedge pclk);
			for (int k = 0; k < 11; k++) begin
				fr[k] = txd_out;
				repeat (bit_clks) @(posedge pclk);
			end
			got <= 1'b1;
			got_val <= {fr[10] & !fr[0], fr[9:1]};
			@(posedge pclk);
			got <= 1'b0;
		end
	end
	// Asynchronous transmitter: start, eight data LSB first, ninth bit, stop
	task automatic send_async(input [7:0] d, input nb);
		reg [10:0] f;
		f = {1'b1, nb, d, 1'b0};
		for (int k = 0; k < 11; k++) begin
			line <= f[k];
			repeat (bit_clks) @(posedge pclk);
		end
	endtask
endmodule

// file: tb_top.sv
// Bench for the serial port: APB access, mode 0 both ways, asynchronous frames, interrupt.
// Assumes the far-end model on the pins; expected results are queued by the driver.
`timescale 1ns/1ns
`include "uart_serial_port_consts.vh"
module tb_top;
	reg         pclk, presetn, psel, penable, pwrite, nb, rb8, ld;
	reg  [7:0]  paddr, b, last_buf;
	reg  [31:0] pwdata;
	wire [31:0] prdata;
	wire        pready, pslverr, rxd_out, rxd_oe, txd_out, irq, line, got, rxd_in;
	wire [9:0]  got_val;
	wire [3:0]  last_low;
	reg  [32:0] exp_q[$];
	reg  [9:0]  ser_q[$];
	reg  [7:0]  regs[5] = '{`OFS_SERIAL_BUFFER, `OFS_SERIAL_CONTROL, `OFS_CONFIG, `OFS_IRQ_STATUS, `OFS_IRQ_MASK};
	int         errors, num_checks, cyc, lows;
	assign rxd_in = rxd_oe ? rxd_out : line;
	uart_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in),
		.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
	uart_far_end far (.pclk(pclk), .txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .line(line),
		.got(got), .got_val(got_val), .last_low(last_low));
	always #20 pclk = ~pclk;
	task automatic check(input string what, input [32:0] seen, input [32:0] want);
		num_checks++;
		if (seen !== want) begin
			errors++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic complete_run;
		$display("Checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// APB transfer: setup, access, hold until pready
	task automatic apb(input w, input [7:0] a, input [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input [7:0] a, input [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		if (irq !== 1'b1)
			errors++;
		repeat (2) @(posedge pclk);
	endtask
	// Result watcher: oldest note against each answer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check("read", {pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h1_dead_beef);
		if (got === 1'b1)
			check("serial", got_val, ser_q.size() ? ser_q.pop_front() : 10'h3ff);
	end
	// Hang limit
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			complete_run();
		end
	end
	initial begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		errors = 0;
		num_checks = 0;
		cyc = 0;
		last_buf = 8'h00;
		rb8 = 0;
		void'($urandom(32'h1f919666));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (regs[k]) rd(regs[k], 33'h0_0000_0000);
		rd(8'h14, 33'h1_0000_0000);
		$display("Test reset and map done");
		wr(`OFS_IRQ_MASK, 32'h3);
		for (int s = 1; s >= 0; s--) begin
			b = $urandom;
			wr(`OFS_SERIAL_CONTROL, s << 5);
			ser_q.push_back({2'b10, b});
			wr(`OFS_SERIAL_BUFFER, b);
			wait_irq();
			check("low run", last_low, s ? 2 : 6);
			rd(`OFS_IRQ_STATUS, 33'h2);
			wr(`OFS_IRQ_STATUS, 32'h2);
			repeat (2) @(posedge pclk);
			check("irq", irq, 0);
		end
		$display("Test mode 0 send done");
		b = $urandom;
		far.m0_tx = b;
		far.i = 0;
		far.line <= b[0];
		wr(`OFS_SERIAL_CONTROL, 32'h10);
		wait_irq();
		lows = 0;
		repeat (30) begin
			@(posedge pclk);
			lows += !txd_out;
		end
		check("no receive", lows, 0);
		wr(`OFS_SERIAL_CONTROL, 32'h0);
		rd(`OFS_SERIAL_BUFFER, b);
		wr(`OFS_IRQ_STATUS, 32'h1);
		last_buf = b;
		$display("Test mode 0 receive done");
		far.async = 1;
		wr(`OFS_IRQ_MASK, 32'h1);
		for (int k = 0; k < 3; k++) begin
			b = $urandom;
			nb = (k == 0) ? $urandom % 2 : k == 2;
			far.bit_clks = (k == 0) ? 32 : 64;
			wr(`OFS_CONFIG, k == 0);
			wr(`OFS_SERIAL_CONTROL, 32'h98 | (k > 0) << 5);
			if (k == 2) begin
				far.line <= 1'b0;
				repeat (4) @(posedge pclk);
				far.line <= 1'b1;
				repeat (200) @(posedge pclk);
				rd(`OFS_IRQ_STATUS, 33'h4);
				wr(`OFS_IRQ_STATUS, 32'h4);
			end
			if (k == 0) begin
				ser_q.push_back({2'b11, b ^ 8'h5a});
				fork
					far.send_async(b, nb);
					wr(`OFS_SERIAL_BUFFER, b ^ 8'h5a);
				join
			end else
				far.send_async(b, nb);
			repeat (80) @(posedge pclk);
			ld = k != 1;
			if (ld) begin
				rb8 = nb;
				last_buf = b;
			end
			rd(`OFS_IRQ_STATUS, {31'h0, k == 0, ld});
			rd(`OFS_SERIAL_CONTROL, {25'h0, 2'b10, k > 0, 2'b11, rb8, k == 0, ld});
			rd(`OFS_SERIAL_BUFFER, last_buf);
			check("irq mask", irq, ld);
			wr(`OFS_IRQ_STATUS, 32'h7);
		end
		$display("Test asynchronous frames done");
		repeat (4) @(posedge pclk);
		check("reads left", exp_q.size(), 0);
		check("serial left", ser_q.size(), 0);
		complete_run();
	end
endmodule
bind uart_serial_port uart_serial_port_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
